// ### hw/cfs_top.sv
// cfs_top: function selection, measurement sequencing, totalize and trigger lights
// assumes APB master on CLK, keypad pulses and signal inputs synchronous to CLK
module cfs_top import cfs_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic KEY_STROBE,
  input wire logic [4:0] KEY_CODE,
  input wire logic ENTRY_ACTIVE,
  input wire logic SIG_A,
  input wire logic SIG_B,
  input wire logic SIG_C,
  input wire logic SIG_V,
  input wire logic RISE_LO_CMP,
  input wire logic RISE_HI_CMP,
  input wire logic ABOVE_A,
  input wire logic ABOVE_B,
  output logic [11:0] FUNC_LED,
  output logic DIGIT_STROBE,
  output logic [3:0] DIGIT_CODE,
  output logic AUTOMATIC_TRIGGER,
  output logic AUTOMATIC_ATTENUATION,
  output logic COMMON_A,
  output logic EXTERNAL_ARM_CHOICE,
  output logic AB_FRONT_EN,
  output logic [1:0] TRIG_POINT,
  output logic GATE_OPEN,
  output logic MEAS_RESTART,
  output logic RESULT_STROBE,
  output logic [1:0] READOUT_SEL,
  output logic [1:0] TRIG_LED
);
  typedef struct packed {
    cfs_func_e func;
    cfs_meas_e meas;
    logic [15:0] gate_ms;
    logic [15:0] delay_ms;
    logic automatic_trigger;
    logic attn;
    logic com_a;
    logic slope_a;
    logic slope_b;
    logic ext_arm;
    logic avg;
    logic [1:0] readout;
    logic [31:0] total;
    logic [31:0] main;
    logic [31:0] ref_cnt;
    logic [31:0] res_main;
    logic [31:0] res_ref;
    logic [6:0] nrun;
    logic [31:0] ms_div;
    logic [15:0] ms_cnt;
    logic [15:0] seq;
    logic [5:0] prev;
    logic [7:0] blink_div;
    logic blink;
    logic [1:0][7:0] act;
    logic digit_v;
    logic [3:0] digit_code;
    logic restart;
    logic res_v;
  } cfs_state_s;

  localparam logic [31:0] MS_M1 = 32'(MS_CYCLES - 1);

  cfs_state_s s_r;
  cfs_state_s s_nxt;
  logic [5:0] cur;
  logic [5:0] rise;
  logic [5:0] fall;
  logic ms_tick;
  logic fkey;
  logic ikey;
  logic volt;
  logic forced_auto;
  logic totmode;
  logic avg_mode;
  logic [15:0] gate_eff;
  logic src_edge;
  logic lead;
  logic trail;
  logic stop_b;
  logic r_start;
  logic r_end;
  logic armed;
  logic ended;
  logic wr;
  logic acc;
  logic [31:0] stat;
  logic [6:0] nrun1;

  assign cur = {RISE_HI_CMP, RISE_LO_CMP, SIG_V, SIG_C, SIG_B, SIG_A};
  assign rise = cur & ~s_r.prev;
  assign fall = ~cur & s_r.prev;
  assign ms_tick = (s_r.ms_div == MS_M1);
  assign fkey = KEY_STROBE && (KEY_CODE < K_RESET);
  assign ikey = KEY_STROBE && !ENTRY_ACTIVE && (KEY_CODE >= K_AUTO) && (KEY_CODE <= K_LEVELS);
  assign volt = (s_r.func == FN_VOLTAGE_MEASURE);
  assign forced_auto = (s_r.func == FN_PULSE_WIDTH) || (s_r.func == FN_RISE_FALL);
  assign totmode = (s_r.func == FN_EVENT_COUNT_BEGIN) || (s_r.func == FN_EVENT_COUNT_HOLD);
  assign avg_mode = s_r.avg && ((s_r.func == FN_PULSE_WIDTH) || (s_r.func == FN_INTERVAL)
                    || (s_r.func == FN_INTERVAL_DELAYED));
  assign gate_eff = volt ? GATE_VOLT_MS : s_r.gate_ms;
  assign lead = s_r.slope_a ? fall[0] : rise[0];
  assign trail = s_r.slope_a ? rise[0] : fall[0];
  assign stop_b = s_r.slope_b ? fall[1] : rise[1];
  assign r_start = s_r.slope_a ? fall[5] : rise[4];
  assign r_end = s_r.slope_a ? fall[4] : rise[5];
  assign nrun1 = 7'(s_r.nrun + 7'h01);
  assign wr = PSEL && PENABLE && PWRITE;
  assign acc = PSEL && PENABLE;

  always_comb begin
    case (s_r.func)
      FN_IN2_FREQUENCY: src_edge = rise[1];
      FN_PRESCALED_FREQUENCY: src_edge = rise[2];
      FN_VOLTAGE_MEASURE: src_edge = rise[3];
      default: src_edge = rise[0];
    endcase
  end

  // arming event and end of gate for each function
  always_comb begin
    armed = 1'b0;
    ended = 1'b0;
    case (s_r.func)
      FN_PERIOD: begin
        armed = rise[0];
        ended = rise[0] && (s_r.ms_cnt >= gate_eff);
      end
      FN_RATIO: begin
        armed = rise[1];
        ended = rise[1] && (32'(s_r.ref_cnt) + 32'h1 >= 32'(gate_eff));
      end
      FN_PULSE_WIDTH: begin
        armed = lead;
        ended = trail;
      end
      FN_INTERVAL: begin
        armed = lead;
        ended = stop_b;
      end
      FN_INTERVAL_DELAYED: begin
        armed = lead;
        ended = stop_b && (s_r.ms_cnt >= s_r.delay_ms);
      end
      FN_RISE_FALL: begin
        armed = r_start;
        ended = r_end;
      end
      FN_EVENT_COUNT_BEGIN, FN_EVENT_COUNT_HOLD: begin
        armed = 1'b0;
        ended = 1'b0;
      end
      default: begin
        armed = src_edge;
        ended = ms_tick && (s_r.ms_cnt + 16'h0001 >= gate_eff);
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = cur;
    s_nxt.digit_v = 1'b0;
    s_nxt.restart = 1'b0;
    s_nxt.res_v = 1'b0;
    s_nxt.ms_div = ms_tick ? 32'h0 : s_r.ms_div + 32'h1;
    // trigger light timing
    if (ms_tick) begin
      if (s_r.blink_div == BLINK_MS - 8'h01) begin
        s_nxt.blink_div = 8'h00;
        s_nxt.blink = ~s_r.blink;
      end else begin
        s_nxt.blink_div = s_r.blink_div + 8'h01;
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (rise[c]) begin
        s_nxt.act[c] = FLASH_MS;
      end else if (ms_tick && (s_r.act[c] != 8'h00)) begin
        s_nxt.act[c] = s_r.act[c] - 8'h01;
      end
    end
    // measurement sequencer
    case (s_r.meas)
      M_ARM: begin
        if (armed) begin
          s_nxt.meas = M_RUN;
          s_nxt.ms_cnt = 16'h0000;
        end
      end
      M_RUN: begin
        if (ms_tick) begin
          s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
        end
        case (s_r.func)
          FN_PERIOD: begin
            s_nxt.main = s_r.main + 32'h1;
            s_nxt.ref_cnt = s_r.ref_cnt + 32'(rise[0]);
          end
          FN_RATIO: begin
            s_nxt.main = s_r.main + 32'(rise[0]);
            s_nxt.ref_cnt = s_r.ref_cnt + 32'(rise[1]);
          end
          FN_PULSE_WIDTH, FN_INTERVAL, FN_INTERVAL_DELAYED, FN_RISE_FALL: begin
            s_nxt.main = s_r.main + 32'h1;
          end
          default: begin
            s_nxt.main = s_r.main + 32'(src_edge);
            s_nxt.ref_cnt = 32'(gate_eff);
          end
        endcase
        if (ended) begin
          s_nxt.meas = M_DONE;
        end
      end
      M_DONE: begin
        s_nxt.meas = M_ARM;
        if (avg_mode && (nrun1 < AVG_RUNS)) begin
          s_nxt.nrun = nrun1;
        end else begin
          s_nxt.res_main = s_r.main;
          s_nxt.res_ref = avg_mode ? 32'(nrun1) : s_r.ref_cnt;
          s_nxt.res_v = 1'b1;
          s_nxt.seq = s_r.seq + 16'h0001;
          s_nxt.main = 32'h0;
          s_nxt.ref_cnt = 32'h0;
          s_nxt.nrun = 7'h00;
        end
      end
      default: begin
        s_nxt.meas = M_IDLE;
      end
    endcase
    // totalize accumulation, manually gated
    if (s_r.func == FN_EVENT_COUNT_BEGIN && rise[0]) begin
      s_nxt.total = s_r.total + 32'h1;
    end
    // keypad
    if (fkey && ENTRY_ACTIVE) begin
      s_nxt.digit_v = 1'b1;
      s_nxt.digit_code = KEY_CODE[3:0];
    end else if (fkey) begin
      s_nxt.func = cfs_func_e'(KEY_CODE[3:0]);
      s_nxt.restart = 1'b1;
      if (!(KEY_CODE[3:0] == FN_EVENT_COUNT_BEGIN && totmode)) begin
        s_nxt.total = (KEY_CODE[3:0] == FN_EVENT_COUNT_HOLD && totmode) ? s_r.total : 32'h0;
      end
    end else if (KEY_STROBE && KEY_CODE == K_RESET) begin
      s_nxt.restart = 1'b1;
      if (totmode) begin
        s_nxt.total = 32'h0;
      end
    end else if (KEY_STROBE && !ENTRY_ACTIVE && KEY_CODE == K_AVG) begin
      s_nxt.avg = ~s_r.avg;
      s_nxt.restart = 1'b1;
    end else if (KEY_STROBE && !ENTRY_ACTIVE && KEY_CODE == K_SLOPEA) begin
      s_nxt.slope_a = ~s_r.slope_a;
      s_nxt.restart = 1'b1;
    end else if (KEY_STROBE && !ENTRY_ACTIVE && KEY_CODE == K_SLOPEB) begin
      s_nxt.slope_b = ~s_r.slope_b;
      s_nxt.restart = 1'b1;
    end
    if (ikey) begin
      if (totmode) begin
        s_nxt.total = 32'h0;
      end
      case (KEY_CODE)
        K_AUTO: s_nxt.automatic_trigger = (forced_auto || volt) ? s_r.automatic_trigger : ~s_r.automatic_trigger;
        K_ATTN: s_nxt.attn = ~s_r.attn;
        K_COMA: s_nxt.com_a = (s_r.func == FN_RISE_FALL) ? s_r.com_a : ~s_r.com_a;
        K_EXTARM: s_nxt.ext_arm = volt ? s_r.ext_arm : ~s_r.ext_arm;
        K_LEVELS: s_nxt.readout = (s_r.readout == READ_LAST) ? 2'h0 : s_r.readout + 2'h1;
        default: s_nxt.readout = s_r.readout;
      endcase
    end
    if (s_nxt.restart) begin
      s_nxt.meas = (s_nxt.func == FN_EVENT_COUNT_BEGIN || s_nxt.func == FN_EVENT_COUNT_HOLD) ? M_IDLE : M_ARM;
      s_nxt.main = 32'h0;
      s_nxt.ref_cnt = 32'h0;
      s_nxt.nrun = 7'h00;
      s_nxt.ms_cnt = 16'h0000;
    end
    // register writes
    if (wr && PADDR == A_GATE && !volt) begin
      s_nxt.gate_ms = PWDATA[15:0];
    end
    if (wr && PADDR == A_DELAY) begin
      s_nxt.delay_ms = PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.func <= FN_IN1_FREQUENCY;
      s_r.meas <= M_ARM;
      s_r.gate_ms <= GATE_RST_MS;
      s_r.delay_ms <= DELAY_RST_MS;
      s_r.automatic_trigger <= 1'b1;
      s_r.attn <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    stat = 32'h0;
    stat[ST_FUNC +: 4] = s_r.func;
    stat[ST_AUTO] = AUTOMATIC_TRIGGER;
    stat[ST_ATTN] = s_r.attn;
    stat[ST_COMA] = COMMON_A;
    stat[ST_SLA] = s_r.slope_a;
    stat[ST_SLB] = s_r.slope_b;
    stat[ST_EXT] = EXTERNAL_ARM_CHOICE;
    stat[ST_AVG] = avg_mode;
    stat[ST_READ +: 2] = s_r.readout;
    stat[ST_TRUN] = (s_r.func == FN_EVENT_COUNT_BEGIN);
    stat[ST_BUSY] = (s_r.meas == M_RUN);
    PSLVERR = 1'b0;
    case (PADDR)
      A_GATE: PRDATA = {16'h0000, gate_eff};
      A_DELAY: PRDATA = {16'h0000, s_r.delay_ms};
      A_STAT: PRDATA = stat;
      A_MAIN: PRDATA = s_r.res_main;
      A_REF: PRDATA = s_r.res_ref;
      A_TOTAL: PRDATA = s_r.total;
      A_SEQ: PRDATA = {16'h0000, s_r.seq};
      default: begin
        PRDATA = 32'h0;
        PSLVERR = acc;
      end
    endcase
  end

  assign PREADY = 1'b1;
  assign DIGIT_STROBE = s_r.digit_v;
  assign DIGIT_CODE = s_r.digit_code;
  assign AUTOMATIC_TRIGGER = forced_auto || (!volt && s_r.automatic_trigger);
  assign AUTOMATIC_ATTENUATION = s_r.attn;
  assign COMMON_A = (s_r.func == FN_RISE_FALL) || s_r.com_a;
  assign EXTERNAL_ARM_CHOICE = !volt && s_r.ext_arm;
  assign AB_FRONT_EN = (s_r.func != FN_PRESCALED_FREQUENCY);
  assign TRIG_POINT = (s_r.func == FN_PULSE_WIDTH) ? TP_MID :
                      (s_r.func == FN_RISE_FALL) ? TP_1090 : TP_NORM;
  assign GATE_OPEN = (s_r.meas == M_RUN);
  assign MEAS_RESTART = s_r.restart;
  assign RESULT_STROBE = s_r.res_v;
  assign READOUT_SEL = s_r.readout;

  for (genvar g = 0; g < NUM_FUNC; g++) begin : g_led
    assign FUNC_LED[g] = (s_r.func == cfs_func_e'(4'(g)));
  end
  for (genvar c = 0; c < NUM_CH; c++) begin : g_trig
    assign TRIG_LED[c] = (s_r.act[c] != 8'h00) ? s_r.blink : (c == 0 ? ABOVE_A : ABOVE_B);
  end

  AST_ONE_FUNC: assert property (@(posedge CLK) disable iff (!RST_N) $onehot(FUNC_LED))
    else $error("function lights not one-hot");
  AST_NEW_FUNC: assert property (@(posedge CLK) disable iff (!RST_N)
    fkey && !ENTRY_ACTIVE |=> s_r.func == cfs_func_e'($past(KEY_CODE[3:0])) && MEAS_RESTART)
    else $error("function key not taken");
  AST_RESET_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
    KEY_STROBE && KEY_CODE == K_RESET |=> $stable(FUNC_LED) && MEAS_RESTART && $stable(READOUT_SEL))
    else $error("reset key changed settings");
  AST_ENTRY_DIGIT: assert property (@(posedge CLK) disable iff (!RST_N)
    fkey && ENTRY_ACTIVE |=> DIGIT_STROBE && $stable(FUNC_LED) && !MEAS_RESTART)
    else $error("entry key changed function");
  AST_PULSE_AUTO: assert property (@(posedge CLK) disable iff (!RST_N)
    s_r.func == FN_PULSE_WIDTH |-> AUTOMATIC_TRIGGER && TRIG_POINT == TP_MID)
    else $error("pulse width not on automatic trigger");
  AST_RISE_FORCE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_r.func == FN_RISE_FALL |-> COMMON_A && AUTOMATIC_TRIGGER && TRIG_POINT == TP_1090)
    else $error("rise/fall routing not forced");
  AST_PRESC_FRONT: assert property (@(posedge CLK) disable iff (!RST_N)
    AB_FRONT_EN == (s_r.func != FN_PRESCALED_FREQUENCY))
    else $error("front end enable wrong");
  AST_DELAY_STOP: assert property (@(posedge CLK) disable iff (!RST_N)
    s_r.meas == M_RUN && s_r.func == FN_INTERVAL_DELAYED && s_r.ms_cnt < s_r.delay_ms |=> s_r.meas != M_DONE)
    else $error("stop taken inside delay");
  AST_TOT_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
    totmode && KEY_STROBE && KEY_CODE == K_RESET |=> s_r.total == 32'h0)
    else $error("totalize not cleared by reset");
  AST_TOT_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    s_r.func == FN_EVENT_COUNT_HOLD && !KEY_STROBE |=> $stable(s_r.total))
    else $error("held total moved");
  AST_VOLT_FIX: assert property (@(posedge CLK) disable iff (!RST_N)
    volt |-> gate_eff == GATE_VOLT_MS && !AUTOMATIC_TRIGGER && !EXTERNAL_ARM_CHOICE)
    else $error("voltage mode settings wrong");
  AST_LEVELS_WRAP: assert property (@(posedge CLK) disable iff (!RST_N)
    ikey && KEY_CODE == K_LEVELS && READOUT_SEL == READ_LAST |=> READOUT_SEL == 2'h0)
    else $error("level readout did not return");
endmodule

// ### hw/cfs_pkg.sv
// cfs_pkg: constants, key codes, register map and types of the function selector
// assumes a 50 MHz clock and a keypad decoder giving one-cycle key pulses
// Contract
// - exactly one function is active; a new key replaces it; its LED shows it.
// - reset key restarts the measurement, keeps function and key settings.
// - during data entry, function keys become digit keys.
// - power-up selects input one frequency, 300 ms gate, auto trigger, auto attenuation.
// - input one/two frequency self-arms on the signal; resolution follows gate time.
// - period mode averages periods whenever the gate exceeds one period.
// - ratio counts input one over a gate-set number of input two cycles.
// - pulse width forces automatic trigger at 50 percent; the pulse is the gate.
// - pulse width averaging raises resolution; slope picks pulse polarity.
// - interval runs from input one start to input two stop, own slopes.
// - interval averaging repeats measurements for finer resolution.
// - rise/fall forces common input and automatic trigger at 10/90 percent.
// - prescaled frequency disables input one/two front end, else like input one.
// - delayed interval ignores stop events until the gate delay elapses.
// - count begin totals input one events, manually gated, gate time unused.
// - in totalize, the reset key clears the count.
// - in totalize, any input-group key clears the count.
// - count hold freezes the total; begin again resumes without clearing.
// - voltage mode fixes 100 ms gate, disables gate entry, auto trigger, arming.
// - input-group keys except level readout toggle on each press; auto, common A and ext arm keys hold their setting while it is forced.
// - level readout steps through three registers, then returns; reset keeps it.
// - trigger light flashes while triggering, else shows input above/below level.
package cfs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam logic [15:0] GATE_RST_MS = 16'h012C;
  localparam logic [15:0] GATE_VOLT_MS = 16'h0064;
  localparam logic [15:0] DELAY_RST_MS = 16'h0001;
  localparam logic [7:0] FLASH_MS = 8'h64;
  localparam logic [7:0] BLINK_MS = 8'h32;
  localparam logic [6:0] AVG_RUNS = 7'h64;
  localparam int NUM_FUNC = 12;
  localparam int NUM_CH = 2;
  // register byte offsets
  localparam logic [11:0] A_GATE = 12'h000;
  localparam logic [11:0] A_DELAY = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_MAIN = 12'h00C;
  localparam logic [11:0] A_REF = 12'h010;
  localparam logic [11:0] A_TOTAL = 12'h014;
  localparam logic [11:0] A_SEQ = 12'h018;
  // status field positions
  localparam int ST_FUNC = 0;
  localparam int ST_AUTO = 4;
  localparam int ST_ATTN = 5;
  localparam int ST_COMA = 6;
  localparam int ST_SLA = 7;
  localparam int ST_SLB = 8;
  localparam int ST_EXT = 9;
  localparam int ST_AVG = 10;
  localparam int ST_READ = 11;
  localparam int ST_TRUN = 13;
  localparam int ST_BUSY = 14;
  // key codes; 0 to 11 are the function keys in enum order
  localparam logic [4:0] K_RESET = 5'h0C;
  localparam logic [4:0] K_AVG = 5'h0D;
  localparam logic [4:0] K_AUTO = 5'h0E;
  localparam logic [4:0] K_ATTN = 5'h0F;
  localparam logic [4:0] K_COMA = 5'h10;
  localparam logic [4:0] K_SLOPEA = 5'h11;
  localparam logic [4:0] K_SLOPEB = 5'h12;
  localparam logic [4:0] K_EXTARM = 5'h13;
  localparam logic [4:0] K_LEVELS = 5'h14;
  localparam logic [1:0] TP_NORM = 2'h0;
  localparam logic [1:0] TP_MID = 2'h1;
  localparam logic [1:0] TP_1090 = 2'h2;
  localparam logic [1:0] READ_LAST = 2'h3;
  typedef enum logic [3:0] {
    FN_IN1_FREQUENCY, FN_PERIOD, FN_RATIO, FN_PULSE_WIDTH, FN_IN2_FREQUENCY, FN_INTERVAL,
    FN_RISE_FALL, FN_PRESCALED_FREQUENCY, FN_INTERVAL_DELAYED, FN_EVENT_COUNT_BEGIN,
    FN_EVENT_COUNT_HOLD, FN_VOLTAGE_MEASURE
  } cfs_func_e;
  typedef enum logic [1:0] {M_IDLE, M_ARM, M_RUN, M_DONE} cfs_meas_e;
endpackage

// ### dv/cfs_src.sv
// cfs_src: measured input signals feeding the function selector
// assumes it shares CLK with the design; outputs change just after a rising edge
module cfs_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic sig_a,
  output logic sig_b,
  output logic sig_c,
  output logic sig_v
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  initial begin
    sig_a = 1'b0;
    sig_b = 1'b0;
    sig_c = 1'b0;
    sig_v = 1'b0;
  end
  // free run: a, c, v together, b at half their rate
  always @(posedge clk) begin
    if (run) begin
      cnt <= (cnt >= half) ? 8'h00 : cnt + 8'h01;
      if (cnt >= half) begin
        sig_a <= ~sig_a;
        sig_c <= ~sig_c;
        sig_v <= ~sig_v;
        if (sig_a) begin
          sig_b <= ~sig_b;
        end
      end
    end
  end
  // exact count of input one events, ends low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      sig_a <= 1'b1;
      repeat (2) @(posedge clk);
      sig_a <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// ### dv/testbench.sv
// testbench: self-checking bench of the function selector top
// assumes cfs_top with a 10-cycle ms tick and cfs_src on the signal inputs
module testbench import cfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, e, KEY_STROBE = 1'b0, ENTRY_ACTIVE = 1'b0;
  logic [4:0] KEY_CODE = 5'h00;
  logic ABOVE_A = 1'b1, ABOVE_B = 1'b0, run = 1'b0, pulse_r, pulse_d;
  logic RISE_LO_CMP = 1'b0, RISE_HI_CMP = 1'b0;
  logic SIG_A, SIG_B, SIG_C, SIG_V, DIGIT_STROBE, AUTOMATIC_TRIGGER, AUTOMATIC_ATTENUATION;
  logic COMMON_A, EXTERNAL_ARM_CHOICE, AB_FRONT_EN, GATE_OPEN, MEAS_RESTART, RESULT_STROBE;
  logic [11:0] FUNC_LED;
  logic [3:0] DIGIT_CODE;
  logic [1:0] TRIG_POINT, READOUT_SEL, TRIG_LED;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  // auto, common, front end, trigger point per function code
  logic [4:0] row [12] = '{5'h14, 5'h14, 5'h14, 5'h15, 5'h14, 5'h14, 5'h1E, 5'h10, 5'h14, 5'h14, 5'h14, 5'h04};

  always #10 CLK = ~CLK;

  cfs_top #(.MS_CYCLES(10)) i_cfs_top (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .KEY_STROBE(KEY_STROBE), .KEY_CODE(KEY_CODE), .ENTRY_ACTIVE(ENTRY_ACTIVE), .SIG_A(SIG_A), .SIG_B(SIG_B),
    .SIG_C(SIG_C), .SIG_V(SIG_V), .RISE_LO_CMP(RISE_LO_CMP), .RISE_HI_CMP(RISE_HI_CMP), .ABOVE_A(ABOVE_A),
    .ABOVE_B(ABOVE_B), .FUNC_LED(FUNC_LED), .DIGIT_STROBE(DIGIT_STROBE), .DIGIT_CODE(DIGIT_CODE),
    .AUTOMATIC_TRIGGER(AUTOMATIC_TRIGGER), .AUTOMATIC_ATTENUATION(AUTOMATIC_ATTENUATION),
    .COMMON_A(COMMON_A), .EXTERNAL_ARM_CHOICE(EXTERNAL_ARM_CHOICE), .AB_FRONT_EN(AB_FRONT_EN),
    .TRIG_POINT(TRIG_POINT), .GATE_OPEN(GATE_OPEN), .MEAS_RESTART(MEAS_RESTART),
    .RESULT_STROBE(RESULT_STROBE), .READOUT_SEL(READOUT_SEL), .TRIG_LED(TRIG_LED));

  cfs_src i_cfs_src (.clk(CLK), .run(run), .half(8'h03), .sig_a(SIG_A), .sig_b(SIG_B), .sig_c(SIG_C),
    .sig_v(SIG_V));

  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic key(input logic [4:0] c);
    KEY_STROBE <= 1'b1;
    KEY_CODE <= c;
    @(posedge CLK);
    KEY_STROBE <= 1'b0;
    #1;
    pulse_r = MEAS_RESTART;
    pulse_d = DIGIT_STROBE;
    @(posedge CLK);
  endtask

  task automatic wait_res();
    int n;
    n = 0;
    // wait for the next result strobe, giving up after 20000 falling edges
    @(negedge CLK);
    while (RESULT_STROBE !== 1'b1 && n < 20000) begin
      @(negedge CLK);
      n++;
    end
    chk({31'h0, RESULT_STROBE}, 32'h1);
    @(posedge CLK);
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge CLK);
    chk({AUTOMATIC_TRIGGER, AUTOMATIC_ATTENUATION, FUNC_LED}, 32'h3001);
    RST_N <= 1'b1;
    @(posedge CLK);
    chk({30'h0, TRIG_LED}, 32'h1);
    apb(1'b0, A_GATE, 32'h0);
    chk(q, 32'h12C);
    for (int i = 0; i < 12; i++) begin
      key(i[4:0]);
      chk({20'h0, FUNC_LED}, 32'h1 << i);
      chk({AUTOMATIC_TRIGGER, COMMON_A, AB_FRONT_EN, TRIG_POINT}, {27'h0, row[i]});
    end
    apb(1'b1, A_GATE, 32'h5);
    apb(1'b0, A_GATE, 32'h0);
    chk(q, 32'h64);
    key(K_AUTO);
    key(K_EXTARM);
    chk({AUTOMATIC_TRIGGER, EXTERNAL_ARM_CHOICE}, 32'h0);
    key(5'h03);
    key(K_AUTO);
    chk({AUTOMATIC_TRIGGER, TRIG_POINT}, 32'h5);
    key(5'h06);
    key(K_COMA);
    chk({AUTOMATIC_TRIGGER, COMMON_A}, 32'h3);
    RISE_LO_CMP <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({31'h0, GATE_OPEN}, 32'h1);
    RISE_HI_CMP <= 1'b1;
    wait_res();
    RISE_LO_CMP <= 1'b0;
    RISE_HI_CMP <= 1'b0;
    apb(1'b0, A_MAIN, 32'h0);
    chk(q, 32'h6);
    apb(1'b1, A_GATE, 32'h2);
    run <= 1'b1;
    key(5'h00);
    wait_res();
    apb(1'b0, A_REF, 32'h0);
    chk(q, 32'h2);
    key(5'h02);
    wait_res();
    apb(1'b0, A_REF, 32'h0);
    chk(q, 32'h2);
    key(5'h05);
    key(K_AVG);
    wait_res();
    apb(1'b0, A_REF, 32'h0);
    chk(q, 32'h64);
    key(K_AVG);
    apb(1'b1, A_DELAY, 32'h3);
    key(5'h08);
    wait_res();
    apb(1'b0, A_MAIN, 32'h0);
    chk({31'h0, q >= 32'h14}, 32'h1);
    key(K_RESET);
    chk({19'h0, pulse_r, FUNC_LED}, 32'h1100);
    ENTRY_ACTIVE <= 1'b1;
    key(5'h04);
    chk({15'h0, pulse_d, DIGIT_CODE, FUNC_LED}, 32'h14100);
    ENTRY_ACTIVE <= 1'b0;
    key(K_ATTN);
    chk({31'h0, AUTOMATIC_ATTENUATION}, 32'h0);
    key(K_ATTN);
    chk({31'h0, AUTOMATIC_ATTENUATION}, 32'h1);
    for (int j = 1; j < 5; j++) begin
      key(K_LEVELS);
      if (j == 2) begin
        key(K_RESET);
      end
      chk({30'h0, READOUT_SEL}, j % 4);
    end
    ABOVE_A <= 1'b0;
    ABOVE_B <= 1'b1;
    @(negedge CLK);
    q = {30'h0, TRIG_LED};
    chk({31'h0, q[1]}, {31'h0, q[0]});
    repeat (BLINK_MS * 10) @(negedge CLK);
    chk({30'h0, TRIG_LED}, {30'h0, ~q[1:0]});
    @(posedge CLK);
    run <= 1'b0;
    i_cfs_src.pulses(1);
    key(5'h09);
    i_cfs_src.pulses(5);
    apb(1'b0, A_TOTAL, 32'h0);
    chk(q, 32'h5);
    key(5'h0A);
    i_cfs_src.pulses(3);
    apb(1'b0, A_TOTAL, 32'h0);
    chk(q, 32'h5);
    key(5'h09);
    i_cfs_src.pulses(2);
    apb(1'b0, A_TOTAL, 32'h0);
    chk(q, 32'h7);
    key(K_RESET);
    apb(1'b0, A_TOTAL, 32'h0);
    chk(q, 32'h0);
    i_cfs_src.pulses(4);
    key(K_SLOPEA);
    apb(1'b0, A_TOTAL, 32'h0);
    chk(q, 32'h0);
    repeat (FLASH_MS * 10 + 20) @(posedge CLK);
    chk({30'h0, TRIG_LED}, 32'h2);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({e, q[30:0]}, 32'h80000000);
    summarize();
  end
endmodule
